// ### common/eepac_pkg.sv
/*
 * eepac_pkg: register map, field positions, reset values, unlock key
 * bytes and write timing for the data eeprom access controller.
 * assumes a 32-bit apb bus with one aligned word per register.
 */
package eepac_pkg;
   // apb byte offsets
   localparam logic [7:0] EEPAC_CTRL_OFS = 8'h00; // eeprom_control
   localparam logic [7:0] EEPAC_UNLOCK_OFS = 8'h04; // eeprom_unlock_port
   localparam logic [7:0] EEPAC_DATA_OFS = 8'h08; // eeprom_data
   localparam logic [7:0] EEPAC_ADDR_OFS = 8'h0c; // eeprom_address
   localparam logic [7:0] EEPAC_FLAG_OFS = 8'h10; // peripheral_flag_reg_2
   // control register fields
   localparam int EEPAC_RD_BIT = 0; // read_start
   localparam int EEPAC_WR_BIT = 1; // write_start
   localparam int EEPAC_PERMIT_BIT = 2; // write_permit
   localparam int EEPAC_ERR_BIT = 3; // write_error_flag
   localparam int EEPAC_FREE_BIT = 4; // row_erase_enable
   localparam int EEPAC_CFG_BIT = 6; // configuration_space_select
   localparam int EEPAC_PGD_BIT = 7; // program_memory_select
   // flag register field
   localparam int EEPAC_DONE_BIT = 4; // write_done_flag
   // unlock key bytes
   localparam logic [7:0] EEPAC_KEY1 = 8'h55;
   localparam logic [7:0] EEPAC_KEY2 = 8'haa;
   // reset values
   localparam logic [7:0] EEPAC_BYTE_RST = 8'h00;
   // self-timed write length in pclk cycles
   localparam int EEPAC_WRITE_CYCLES = 1000;
   localparam int EEPAC_CNT_W = 16;
   // unlock sequence tracker
   typedef enum logic [1:0] {
      EEPAC_LOCKED,
      EEPAC_GOT_KEY1,
      EEPAC_ARMED
   } eepac_unlock_type;
endpackage : eepac_pkg

// ### verilog/eepac_top.sv
/*
 * eepac_top: apb register front end, unlock sequencer, self-timed
 * write engine and 256-byte data array of the eeprom access block.
 * assumes a single 250 mhz pclk, async active-low presetn, a pin-level
 * external reset request and a same-clock watchdog reset request.
 */
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module eepac_top #(
   parameter int WRITE_CYCLES = eepac_pkg::EEPAC_WRITE_CYCLES,
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic external_reset_pin_n,
   input wire logic watchdog_reset,
   output logic flash_write_pulse,
   output logic flash_row_erase_pulse,
   output logic config_write_pulse,
   output logic nvm_busy
);
   import eepac_pkg::*;

   localparam int DEPTH = 1 << ADDR_W;
   localparam logic [EEPAC_CNT_W-1:0] CNT_LAST =
      EEPAC_CNT_W'(WRITE_CYCLES - 1);

   // storage array, no reset
   logic [7:0] mem [DEPTH];
   // software visible state
   logic [ADDR_W-1:0] addr_q;
   logic [7:0] data_q;
   logic pgd_q, cfg_q, free_q, err_q, permit_q, wr_q, rd_q;
   logic done_q;
   // write engine state
   logic [EEPAC_CNT_W-1:0] cnt_q;
   logic [ADDR_W-1:0] wr_addr_q;
   logic [7:0] wr_data_q;
   logic wr_pgd_q, wr_cfg_q;
   eepac_unlock_type unlock_q;
   // reset request synchroniser
   logic ext_meta_q, ext_sync_q;
   // apb answer flops
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic flash_wr_q, flash_er_q, cfg_wr_q;

   // bus decode
   wire [7:0] ofs = paddr[7:0];
   wire hit_ctrl = ofs == EEPAC_CTRL_OFS;
   wire hit_unlock = ofs == EEPAC_UNLOCK_OFS;
   wire hit_data = ofs == EEPAC_DATA_OFS;
   wire hit_addr = ofs == EEPAC_ADDR_OFS;
   wire hit_flag = ofs == EEPAC_FLAG_OFS;
   wire mapped = (paddr[31:8] == 24'h000000) &
      (hit_ctrl | hit_unlock | hit_data | hit_addr | hit_flag);
   wire setup = psel & ~penable;
   wire acc_wr = psel & penable & pwrite & mapped & pstrb[0];
   wire wr_ctrl = acc_wr & hit_ctrl;
   wire wr_unlock = acc_wr & hit_unlock;
   wire wr_data = acc_wr & hit_data;
   wire wr_addr = acc_wr & hit_addr;
   wire wr_flag = acc_wr & hit_flag;
   wire [7:0] wbyte = pwdata[7:0];

   // core reset request: pin after sync, or watchdog
   wire abort = ~ext_sync_q | watchdog_reset;
   // write engine events
   wire wr_done = wr_q & (cnt_q == CNT_LAST) & ~abort;
   // routing of the access
   wire ee_route = ~pgd_q & ~cfg_q;
   // launch needs armed unlock and a permit set earlier
   wire wr_launch = wr_ctrl & wbyte[EEPAC_WR_BIT] & permit_q & ~wr_q &
      (unlock_q == EEPAC_ARMED) & ~abort;
   // read start refused with program select set
   wire rd_launch = wr_ctrl & wbyte[EEPAC_RD_BIT] &
      ~wbyte[EEPAC_PGD_BIT] & ~abort;
   // array read port
   wire [7:0] mem_rd = mem[addr_q];
   // data value as seen after a pending read lands
   wire [7:0] data_fwd = (rd_q & ee_route) ? mem_rd : data_q;
   wire [7:0] ctrl_rd = {pgd_q, cfg_q, 1'b0, free_q, err_q, permit_q,
      wr_q, rd_q};
   wire [7:0] rd_byte =
      hit_ctrl ? ctrl_rd :
      hit_data ? data_fwd :
      hit_addr ? 8'(addr_q) :
      hit_flag ? 8'(done_q) << EEPAC_DONE_BIT :
      8'h00; // unlock port and others read zero

   assign prdata = prdata_q;
   assign pready = 1'b1;
   assign pslverr = pslverr_q;
   assign flash_write_pulse = flash_wr_q;
   assign flash_row_erase_pulse = flash_er_q;
   assign config_write_pulse = cfg_wr_q;
   assign nvm_busy = wr_q;

   // two-flop sync of the external reset pin
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_meta_q <= 1'b1;
         ext_sync_q <= 1'b1;
      end else begin
         ext_meta_q <= external_reset_pin_n;
         ext_sync_q <= ext_meta_q;
      end
   end

   // apb read data and error captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
         pslverr_q <= 1'b0;
      end else if (setup) begin
         prdata_q <= {24'h000000, rd_byte};
         pslverr_q <= ~mapped;
      end
   end

   // unlock tracker, any other write breaks it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         unlock_q <= EEPAC_LOCKED;
      end else if (abort) begin
         unlock_q <= EEPAC_LOCKED;
      end else if (acc_wr) begin
         case (unlock_q)
            EEPAC_LOCKED: begin
               unlock_q <= (wr_unlock && wbyte == EEPAC_KEY1) ?
                  EEPAC_GOT_KEY1 : EEPAC_LOCKED;
            end
            EEPAC_GOT_KEY1: begin
               unlock_q <= (wr_unlock && wbyte == EEPAC_KEY2) ?
                  EEPAC_ARMED : EEPAC_LOCKED;
            end
            default: begin
               unlock_q <= EEPAC_LOCKED; // one write per unlock
            end
         endcase
      end
   end

   // control bits: program and config select, row erase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pgd_q <= 1'b0;
         cfg_q <= 1'b0;
         free_q <= 1'b0;
      end else if (wr_done) begin
         free_q <= 1'b0;
      end else if (wr_ctrl && !abort) begin
         pgd_q <= wbyte[EEPAC_PGD_BIT];
         cfg_q <= wbyte[EEPAC_CFG_BIT];
         free_q <= wbyte[EEPAC_FREE_BIT];
      end
      // abort leaves these untouched
   end

   // write permit and error flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         permit_q <= 1'b0;
         err_q <= 1'b0;
      end else if (abort) begin
         permit_q <= 1'b0;
         err_q <= err_q | wr_q;
      end else if (wr_done) begin
         err_q <= 1'b0;
      end else if (wr_ctrl) begin
         permit_q <= wbyte[EEPAC_PERMIT_BIT];
         err_q <= wbyte[EEPAC_ERR_BIT];
      end
   end

   // start bits: software sets, hardware clears
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else if (abort) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
      end else begin
         wr_q <= wr_launch | (wr_q & ~wr_done);
         rd_q <= rd_launch; // one cycle
      end
   end

   // self-timed write counter and captured target
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         wr_addr_q <= '0;
         wr_data_q <= EEPAC_BYTE_RST;
         wr_pgd_q <= 1'b0;
         wr_cfg_q <= 1'b0;
      end else if (wr_launch) begin
         cnt_q <= '0;
         wr_addr_q <= addr_q;
         wr_data_q <= data_q;
         wr_pgd_q <= pgd_q;
         wr_cfg_q <= cfg_q;
      end else if (wr_q) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end

   // outward pulses for flash and config targets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flash_wr_q <= 1'b0;
         flash_er_q <= 1'b0;
         cfg_wr_q <= 1'b0;
      end else begin
         flash_wr_q <= wr_launch & pgd_q & ~cfg_q & ~free_q;
         flash_er_q <= wr_launch & pgd_q & ~cfg_q & free_q;
         cfg_wr_q <= wr_launch & cfg_q;
      end
   end

   // array write at end of the erase-then-program cycle
   always_ff @(posedge pclk) begin
      if (wr_done && !wr_pgd_q && !wr_cfg_q) begin
         mem[wr_addr_q] <= wr_data_q;
      end
   end

   // address and data registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         addr_q <= '0;
         data_q <= EEPAC_BYTE_RST;
      end else if (abort) begin
         addr_q <= '0;
         data_q <= EEPAC_BYTE_RST;
      end else begin
         if (wr_addr) begin
            addr_q <= wbyte[ADDR_W-1:0];
         end
         if (rd_q && ee_route) begin
            data_q <= mem_rd;
         end else if (wr_data) begin
            data_q <= wbyte;
         end
      end
   end

   // done flag: hardware set beats software clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_q <= 1'b0;
      end else if (wr_done) begin
         done_q <= 1'b1;
      end else if (wr_flag) begin
         done_q <= wbyte[EEPAC_DONE_BIT];
      end
   end

   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_unlocked;
      unlock_q == EEPAC_ARMED;
   endsequence
   sequence s_start_req;
      wr_ctrl && wbyte[EEPAC_WR_BIT];
   endsequence

   read_clear_a: assert property (rd_q |=> !rd_q)
      else $error("read_start stayed set");
   read_data_a: assert property (rd_q && ee_route && !abort
      |=> data_q == $past(mem_rd))
      else $error("read data not loaded next cycle");
   read_block_a: assert property (wr_ctrl && wbyte[EEPAC_PGD_BIT]
      |=> !rd_q)
      else $error("read started with program select");
   unlock_zero_a: assert property (setup && hit_unlock
      |=> prdata == 32'h00000000)
      else $error("unlock port read nonzero");
   start_gate_a: assert property (!wr_q ##1 wr_q
      |-> $past(permit_q) && $past(unlock_q == EEPAC_ARMED))
      else $error("write launched without unlock and permit");
   start_take_a: assert property (s_unlocked and s_start_req
      and (permit_q && !wr_q && !abort) |=> wr_q)
      else $error("armed write not launched");
   write_end_a: assert property (wr_done
      |=> !wr_q && done_q && !err_q)
      else $error("write completion effects missing");
   abort_effect_a: assert property (abort && wr_q |=> err_q && !wr_q
      && addr_q == '0 && data_q == 8'h00
      && $stable(pgd_q) && $stable(free_q))
      else $error("aborted write effects wrong");
   sw_hold_a: assert property (wr_q && !wr_done && !abort
      |=> wr_q)
      else $error("write_start cleared early");
   done_hold_a: assert property (done_q && !wr_flag |=> done_q)
      else $error("done flag cleared by hardware");
   write_len_a: assert property (wr_q && !abort
      |-> cnt_q <= CNT_LAST)
      else $error("write counter overran");
endmodule : eepac_top
`default_nettype wire

// ### verif/eepac_nvm_model.sv
/*
 * eepac_nvm_model: far side of the access block, counting launch
 * pulses toward flash and config space, and raising watchdog or
 * external pin resets when the bench asks for one.
 * assumes the same pclk and presetn as the block.
 */
`timescale 1ns/10ps
`default_nettype none
module eepac_nvm_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic flash_write_pulse,
   input wire logic flash_row_erase_pulse,
   input wire logic config_write_pulse,
   input wire logic [1:0] abort_req,
   output logic watchdog_reset,
   output logic external_reset_pin_n,
   output logic [7:0] n_fw,
   output logic [7:0] n_er,
   output logic [7:0] n_cfg
);
   logic [2:0] pin_cnt_q; // cycles the pin stays low

   // count launches; one-cycle watchdog pulse, 4-cycle pin pulse
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         n_fw <= 8'h00;
         n_er <= 8'h00;
         n_cfg <= 8'h00;
         watchdog_reset <= 1'b0;
         pin_cnt_q <= 3'h0;
      end else begin
         n_fw <= n_fw + 8'(flash_write_pulse);
         n_er <= n_er + 8'(flash_row_erase_pulse);
         n_cfg <= n_cfg + 8'(config_write_pulse);
         watchdog_reset <= abort_req[0];
         if (abort_req[1]) begin
            pin_cnt_q <= 3'h4;
         end else if (pin_cnt_q != 3'h0) begin
            pin_cnt_q <= pin_cnt_q - 3'h1;
         end
      end
   end
   assign external_reset_pin_n = (pin_cnt_q == 3'h0);
endmodule : eepac_nvm_model
`default_nettype wire

// ### verif/tb_top.sv
/*
 * tb_top: apb bench for the eeprom access block, with a byte model
 * of the array kept in the bench.
 * assumes zero-wait apb and a shortened self-timed write.
 */
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin n_checks++; if ((s) !== (e)) begin \
 n_mismatch++; $display("ERROR %s exp %h got %h", nm, e, s); end end
module tb_top;
   import eepac_pkg::*;
   localparam int WC = 8; // short write time
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [31:0] paddr = '0, pwdata = '0, prdata;
   logic [3:0] pstrb = 4'hf;
   logic pready, pslverr, fwp, erp, cfp, nvm_busy, wdog_rst, pin_n, er;
   logic [1:0] abort_req = 2'b00;
   logic [7:0] n_fw, n_er, n_cfg, rd, a, d;
   logic [7:0] mem [int]; // byte model of the array
   logic [7:0] mode [4] = '{8'h00, 8'h80, 8'h40, 8'h90};
   int n_mismatch = 0, n_checks = 0, seed = 36967, n;

   always #2 pclk = ~pclk;

   eepac_top #(.WRITE_CYCLES(WC)) eepac_top_i (.pclk(pclk),
      .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .external_reset_pin_n(pin_n),
      .watchdog_reset(wdog_rst), .flash_write_pulse(fwp),
      .flash_row_erase_pulse(erp), .config_write_pulse(cfp),
      .nvm_busy(nvm_busy));
   eepac_nvm_model eepac_nvm_model_i (.pclk(pclk), .presetn(presetn),
      .flash_write_pulse(fwp), .flash_row_erase_pulse(erp),
      .config_write_pulse(cfp), .abort_req(abort_req),
      .watchdog_reset(wdog_rst), .external_reset_pin_n(pin_n),
      .n_fw(n_fw), .n_er(n_er), .n_cfg(n_cfg));

   // one apb transfer: setup, access held until pready
   task automatic apb(input logic w, input logic [7:0] ad,
                      input logic [7:0] dt);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {24'h0, ad};
      pwdata <= {24'h0, dt};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
      apb(1'b1, ad, dt);
   endtask : wr

   task automatic chk(input logic [7:0] ad, input logic [7:0] e,
                      input string nm);
      apb(1'b0, ad, 8'h00);
      `CHK(nm, e, rd)
   endtask : chk

   // permit first, then unlock keys, then start
   task automatic go(input logic [7:0] m);
      wr(EEPAC_CTRL_OFS, m | 8'h04);
      wr(EEPAC_UNLOCK_OFS, EEPAC_KEY1);
      wr(EEPAC_UNLOCK_OFS, EEPAC_KEY2);
      wr(EEPAC_CTRL_OFS, m | 8'h06);
   endtask : go

   // count cycles while busy, bounded
   task automatic wait_busy;
      #1;
      n = 0;
      while (nvm_busy === 1'b1 && n < 100) begin
         @(posedge pclk);
         #1;
         n++;
      end
      // a write that never ends counts as a mismatch
      if (n >= 100) n_mismatch++;
   endtask : wait_busy

   task automatic stop_test;
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : stop_test

   // hang guard
   initial begin
      #40000;
      n_mismatch++;
      stop_test();
   end

   // main sequence
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      chk(EEPAC_CTRL_OFS, 8'h00, "ctrl_rst");
      chk(EEPAC_ADDR_OFS, 8'h00, "addr_rst");
      wr(EEPAC_UNLOCK_OFS, EEPAC_KEY1);
      chk(EEPAC_UNLOCK_OFS, 8'h00, "unlock");
      apb(1'b0, 8'h14, 8'h00);
      `CHK("slverr", 1'b1, er)
      // each route and row erase
      for (int i = 0; i < 4; i++) begin
         go(mode[i]);
         if (i == 0) mem[0] = 8'h00; // reset address and data written
         wait_busy();
         `CHK("wtime", WC, n)
         chk(EEPAC_FLAG_OFS, 8'h10, "done");
         wr(EEPAC_FLAG_OFS, 8'h00);
         chk(EEPAC_CTRL_OFS, (mode[i] & 8'hc0) | 8'h04, "ctrl");
         `CHK("cfg", 8'(i > 1), n_cfg)
         `CHK("erase", 8'(i > 2), n_er)
         if (i < 3) `CHK("flash", 8'(i > 0), n_fw)
      end
      // read blocked while program select set
      wr(EEPAC_DATA_OFS, 8'h3c);
      wr(EEPAC_CTRL_OFS, 8'h81);
      chk(EEPAC_DATA_OFS, 8'h3c, "noread");
      chk(EEPAC_CTRL_OFS, 8'h80, "rd_blk");
      // read with config select set loads nothing
      wr(EEPAC_CTRL_OFS, 8'h41);
      chk(EEPAC_DATA_OFS, 8'h3c, "cfgread");
      // permit and start in one write is refused
      wr(EEPAC_UNLOCK_OFS, EEPAC_KEY1);
      wr(EEPAC_UNLOCK_OFS, EEPAC_KEY2);
      wr(EEPAC_CTRL_OFS, 8'h06);
      #1 `CHK("same", 1'b0, nvm_busy)
      // broken unlock sequence
      wr(EEPAC_UNLOCK_OFS, EEPAC_KEY1);
      wr(EEPAC_DATA_OFS, 8'h11);
      wr(EEPAC_UNLOCK_OFS, EEPAC_KEY2);
      wr(EEPAC_CTRL_OFS, 8'h06);
      #1 `CHK("broken", 1'b0, nvm_busy)
      // random eeprom writes, permit dropped mid-write
      for (int i = 0; i < 4; i++) begin
         a = (i == 0) ? 8'hff : 8'($random(seed));
         d = 8'($random(seed));
         wr(EEPAC_ADDR_OFS, a);
         wr(EEPAC_DATA_OFS, d);
         go(8'h00);
         mem[a] = d;
         wr(EEPAC_CTRL_OFS, 8'h00);
         #1 `CHK("hold", 1'b1, nvm_busy)
         wait_busy();
         wr(EEPAC_FLAG_OFS, 8'h00);
         wr(EEPAC_DATA_OFS, ~d);
         wr(EEPAC_CTRL_OFS, 8'h01);
         chk(EEPAC_DATA_OFS, mem[a], "rdata");
         chk(EEPAC_CTRL_OFS, 8'h00, "rd_clr");
      end
      foreach (mem[k]) begin
         wr(EEPAC_ADDR_OFS, 8'(k));
         wr(EEPAC_CTRL_OFS, 8'h01);
         chk(EEPAC_DATA_OFS, mem[k], "keep");
      end
      // watchdog then pin reset during a write
      for (int s = 0; s < 2; s++) begin
         wr(EEPAC_ADDR_OFS, 8'h21);
         wr(EEPAC_DATA_OFS, 8'h77);
         go(8'h90);
         abort_req <= s[0] ? 2'b10 : 2'b01;
         @(posedge pclk);
         abort_req <= 2'b00;
         wait_busy();
         chk(EEPAC_CTRL_OFS, 8'h98, "abort");
         chk(EEPAC_ADDR_OFS, 8'h00, "a_zero");
         chk(EEPAC_DATA_OFS, 8'h00, "d_zero");
      end
      stop_test();
   end
endmodule : tb_top
`default_nettype wire
